// ### rtl/ccd_timing_pkg.sv
// Constants for the CCD timing controller
`default_nettype none
package ccd_timing_pkg;
  localparam int CLK_HZ = 50000000;
  localparam int VCLK_PERIOD_NS = 2000;
  localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;
  localparam int VCLK_CYC = (VCLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VHALF_CYC = (VCLK_CYC + 1) / 2;
  localparam int XFER_WIDTH_NS = 4000;
  localparam int XFER_CYC = (XFER_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHUT_WIDTH_NS = 4000;
  localparam int SHUT_CYC = (SHUT_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HDIV = 2;
  localparam int LINE_PIX = 2128;
  localparam int FRAME_LINES = 2112;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [1:0] GAIN_HIGH = 2'h0;
  localparam logic [1:0] GAIN_LOW = 2'h1;
  localparam logic [1:0] GAIN_EXT = 2'h2;
  // One extra cycle per half-pixel: line time grows by half, frame rate drops by a third
  localparam int EXT_GAP_CYC = 1;
endpackage
`default_nettype wire

// ### rtl/ccd_pixel_div.sv
// Horizontal pixel-rate enable divider
`default_nettype none
module ccd_pixel_div
  import ccd_timing_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Control
  input  wire logic run,
  input  wire logic stretch,
  // Pixel-phase enable pulse
  output logic      tick
);
  import ccd_timing_pkg::*;

  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } div_t;

  div_t state_reg;
  div_t state_next;

  always_comb
  begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (!run)
    begin
      state_next.cnt = 4'h0;
    end
    else if (state_reg.cnt >= 4'(stretch ? HDIV + EXT_GAP_CYC - 1 : HDIV - 1))
    begin
      state_next.cnt = 4'h0;
      state_next.tick = 1'b1;
    end
    else
    begin
      state_next.cnt = state_reg.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign tick = state_reg.tick;
endmodule
`default_nettype wire

// ### rtl/ccd_timing_ctrl.sv
// Timing generator driving an interline CCD and its analog front ends
`default_nettype none
module ccd_timing_ctrl
  import ccd_timing_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Mode and commands (same clock domain)
  input  wire logic       start_frame,
  input  wire logic       quarter_res,
  input  wire logic [1:0] gain_mode,
  input  wire logic       constant_hrate,
  input  wire logic       shutter_req,
  input  wire logic       shutter_in_frame,
  // Sensor pins
  output logic            top_transfer_phase,
  output logic            bottom_transfer_phase,
  output logic            vclk,
  output logic            hclk1,
  output logic            hclk2,
  output logic            high_gain_reset_a,
  output logic            high_gain_reset_b,
  output logic            high_gain_reset_c,
  output logic            low_gain_reset_upper,
  output logic            low_gain_reset_lower,
  output logic            shutter_pulse,
  // Front end strobes
  output logic            reference_sample_strobe,
  output logic            video_sample_strobe,
  output logic            low_gain_reference_strobe,
  output logic            low_gain_video_strobe,
  output logic            high_gain_reference_strobe,
  output logic            high_gain_video_strobe,
  // Status
  output logic            busy
);
  import ccd_timing_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_XFER,
    ST_VSHIFT,
    ST_HREAD,
    ST_SHUT,
    ST_SHUT_WAIT
  } phase_t;

  typedef struct packed {
    phase_t           phase;
    logic [CNT_W-1:0] tcnt;
    logic [CNT_W-1:0] pix;
    logic [CNT_W-1:0] line;
    logic [1:0]       vsum;
    logic             hph;
    logic             sum_ph;
    logic             shut_pend;
    logic             in_frame;
    logic             xfer;
    logic             vclk;
    logic             h1, h2;
    logic             rhg, rlg;
    logic             shut, busy;
    logic             ref_stb, vid_stb;
    logic             ref_lg, vid_lg;
    logic             ref_hg, vid_hg;
  } ctrl_t;

  ctrl_t state_reg;
  ctrl_t state_next;
  logic  htick;
  logic  hrun;
  logic  ext_range;
  logic  summed;

  assign ext_range = (gain_mode == GAIN_EXT);
  assign summed = quarter_res | ext_range;
  assign hrun = (state_reg.phase == ST_HREAD);

  // Pixel rate from the master clock; stretched clocking in extended range when constant_hrate is set
  ccd_pixel_div u_div (
    .clk     (clk),
    .resetn  (resetn),
    .run     (hrun),
    .stretch (ext_range & constant_hrate),
    .tick    (htick)
  );

  always_comb
  begin
    state_next = state_reg;
    state_next.ref_stb = 1'b0;
    state_next.vid_stb = 1'b0;
    state_next.ref_lg = 1'b0;
    state_next.vid_lg = 1'b0;
    state_next.ref_hg = 1'b0;
    state_next.vid_hg = 1'b0;
    state_next.rhg = 1'b0;
    state_next.rlg = 1'b0;
    if (shutter_req)
    begin
      state_next.shut_pend = 1'b1;
      state_next.in_frame = shutter_in_frame;
    end
    case (state_reg.phase)
      ST_IDLE:
      begin
        state_next.h1 = 1'b0;
        state_next.h2 = 1'b1;
        if (start_frame)
        begin
          state_next.phase = ST_XFER;
          state_next.tcnt = CNT_RESET;
          state_next.xfer = 1'b1;
          state_next.line = CNT_RESET;
        end
      end
      ST_XFER:
      begin
        state_next.tcnt = state_reg.tcnt + 16'h0001;
        if (state_reg.tcnt == 16'(XFER_CYC - 1))
        begin
          state_next.xfer = 1'b0;
          state_next.phase = ST_VSHIFT;
          state_next.tcnt = CNT_RESET;
          state_next.vsum = 2'h0;
        end
      end
      ST_VSHIFT:
      begin
        state_next.tcnt = state_reg.tcnt + 16'h0001;
        if (state_reg.tcnt == 16'(VHALF_CYC - 1))
        begin
          state_next.vclk = 1'b1;
        end
        if (state_reg.tcnt == 16'(VCLK_CYC - 1))
        begin
          state_next.vclk = 1'b0;
          state_next.tcnt = CNT_RESET;
          state_next.line = state_reg.line + 16'h0001;
          state_next.vsum = state_reg.vsum + 2'h1;
          if (state_reg.shut_pend && state_reg.in_frame)
          begin
            state_next.phase = ST_SHUT_WAIT;
          end
          else if (!ext_range || state_reg.vsum == 2'h1)
          begin
            state_next.phase = ST_HREAD;
            state_next.pix = CNT_RESET;
            state_next.sum_ph = 1'b0;
          end
        end
      end
      ST_HREAD:
      begin
        if (htick)
        begin
          state_next.hph = ~state_reg.hph;
          state_next.h1 = ~state_reg.hph;
          state_next.h2 = state_reg.hph;
          if (state_reg.hph)
          begin
            state_next.pix = state_reg.pix + 16'h0001;
            state_next.sum_ph = ~state_reg.sum_ph;
            if (!summed || state_reg.sum_ph)
            begin
              state_next.rhg = (gain_mode != GAIN_LOW);
              state_next.rlg = (gain_mode != GAIN_HIGH);
            end
          end
          else
          begin
            state_next.ref_stb = !ext_range && (!summed || state_reg.sum_ph);
            state_next.vid_stb = !ext_range && (!summed || !state_reg.sum_ph);
            state_next.ref_lg = ext_range && state_reg.sum_ph;
            state_next.ref_hg = ext_range && state_reg.sum_ph;
            state_next.vid_lg = ext_range && !state_reg.sum_ph;
            state_next.vid_hg = ext_range && !state_reg.sum_ph;
          end
          if (state_reg.hph && state_reg.pix == 16'(LINE_PIX - 1))
          begin
            state_next.tcnt = CNT_RESET;
            state_next.hph = 1'b0;
            state_next.h1 = 1'b0;
            state_next.h2 = 1'b1;
            if (state_reg.shut_pend && !state_reg.in_frame)
            begin
              state_next.phase = ST_SHUT;
              state_next.shut = 1'b1;
            end
            else if (state_reg.line >= 16'(FRAME_LINES))
            begin
              state_next.phase = ST_IDLE;
            end
            else
            begin
              state_next.phase = ST_VSHIFT;
              state_next.vsum = 2'h0;
            end
          end
        end
      end
      ST_SHUT:
      begin
        state_next.tcnt = state_reg.tcnt + 16'h0001;
        if (state_reg.tcnt == 16'(SHUT_CYC - 1))
        begin
          state_next.shut = 1'b0;
          state_next.shut_pend = shutter_req;
          state_next.phase = ST_SHUT_WAIT;
          state_next.tcnt = CNT_RESET;
        end
      end
      ST_SHUT_WAIT:
      begin
        state_next.tcnt = state_reg.tcnt + 16'h0001;
        if (state_reg.tcnt == 16'(VHALF_CYC - 1))
        begin
          if (state_reg.shut)
          begin
            state_next.shut = 1'b0;
            state_next.shut_pend = shutter_req;
          end
          else if (state_reg.shut_pend)
          begin
            state_next.shut = 1'b1;
          end
          state_next.tcnt = CNT_RESET;
          if (!state_reg.shut && !state_reg.shut_pend)
          begin
            state_next.phase = (state_reg.line >= 16'(FRAME_LINES)) ? ST_IDLE : ST_VSHIFT;
            state_next.vsum = 2'h0;
          end
        end
      end
      default:
      begin
        state_next.phase = ST_IDLE;
      end
    endcase
    state_next.busy = (state_next.phase != ST_IDLE);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  chk_shut_hempty: assert property (@(posedge clk) disable iff (!resetn)
    state_reg.shut |-> !hrun)
    else $error("shutter asserted while horizontal readout active");

  chk_vclk_after_shut: assert property (@(posedge clk) disable iff (!resetn)
    $fell(state_reg.shut) |-> !state_reg.vclk [*8])
    else $error("vertical clock too soon after shutter");

  chk_xfer_width: assert property (@(posedge clk) disable iff (!resetn)
    $rose(state_reg.xfer) |-> state_reg.xfer [*8])
    else $error("transfer pulse too short");

  chk_xfer_end: assert property (@(posedge clk) disable iff (!resetn)
    $fell(state_reg.xfer) |-> state_reg.phase == ST_VSHIFT)
    else $error("transfer end not followed by vertical shift");

  chk_lowgain_rhg: assert property (@(posedge clk) disable iff (!resetn)
    (gain_mode == GAIN_LOW) && $stable(gain_mode) |=> !state_reg.rhg)
    else $error("high gain reset pulsed in low gain");

  chk_highgain_rlg: assert property (@(posedge clk) disable iff (!resetn)
    (gain_mode == GAIN_HIGH) && $stable(gain_mode) |=> !state_reg.rlg)
    else $error("low gain reset pulsed in high gain");

  chk_shut_vclk: assert property (@(posedge clk) disable iff (!resetn)
    $changed(state_reg.shut) |-> !$changed(state_reg.vclk))
    else $error("shutter edge coincides with vertical edge");

  chk_ext_strobes: assert property (@(posedge clk) disable iff (!resetn)
    state_reg.ref_lg |-> state_reg.ref_hg && !state_reg.ref_stb)
    else $error("extended range strobe pair mismatch");

  chk_strobe_rate: assert property (@(posedge clk) disable iff (!resetn)
    state_reg.ref_stb && summed |-> !state_reg.vid_stb)
    else $error("summed strobes overlap");

  assign top_transfer_phase = state_reg.xfer;
  assign bottom_transfer_phase = state_reg.xfer;
  assign vclk = state_reg.vclk;
  assign hclk1 = state_reg.h1;
  assign hclk2 = state_reg.h2;
  assign high_gain_reset_a = state_reg.rhg;
  assign high_gain_reset_b = state_reg.rhg;
  assign high_gain_reset_c = state_reg.rhg;
  assign low_gain_reset_upper = state_reg.rlg;
  assign low_gain_reset_lower = state_reg.rlg;
  assign shutter_pulse = state_reg.shut;
  assign reference_sample_strobe = state_reg.ref_stb;
  assign video_sample_strobe = state_reg.vid_stb;
  assign low_gain_reference_strobe = state_reg.ref_lg;
  assign low_gain_video_strobe = state_reg.vid_lg;
  assign high_gain_reference_strobe = state_reg.ref_hg;
  assign high_gain_video_strobe = state_reg.vid_hg;
  assign busy = state_reg.busy;
endmodule
`default_nettype wire

// ### verif/ccd_sensor_model.sv
// Behavioural model of the sensor's photodiode-to-vertical transfer
`default_nettype none
module ccd_sensor_model
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Transfer phases from the controller
  input  wire logic top_transfer_phase,
  input  wire logic bottom_transfer_phase,
  // Sensor state seen by the bench
  output var logic  antibloom_on,
  output var int    transfers,
  output var int    last_width
);
  timeunit 1ns;
  timeprecision 1ps;
  logic both;
  logic both_q;
  int   width;
  assign both = top_transfer_phase & bottom_transfer_phase;
  // Blooming drain is off while both phases are high
  assign antibloom_on = ~both;
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      both_q <= 1'b0;
      width <= 0;
      transfers <= 0;
      last_width <= 0;
    end
    else
    begin
      both_q <= both;
      // Charge moves from the rising edge until the falling edge
      if (both === 1'b1)
        width <= (both_q === 1'b1) ? width + 1 : 1;
      // Exposure ends at the falling edge
      if (both === 1'b0 && both_q === 1'b1)
      begin
        transfers <= transfers + 1;
        last_width <= width;
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/ccd_timing_ctrl_tb_top.sv
// Self-checking bench for the CCD timing controller
`default_nettype none
module ccd_timing_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ccd_timing_pkg::*;
  logic       clk, resetn, start_frame, quarter_res, constant_hrate;
  logic       shutter_req, shutter_in_frame, clr_cnt;
  logic [1:0] gain_mode;
  logic       top_transfer_phase, bottom_transfer_phase, vclk, hclk1, hclk2, busy;
  logic       high_gain_reset_a, high_gain_reset_b, high_gain_reset_c, shutter_pulse;
  logic       low_gain_reset_upper, low_gain_reset_lower;
  logic       reference_sample_strobe, video_sample_strobe;
  logic       low_gain_reference_strobe, low_gain_video_strobe;
  logic       high_gain_reference_strobe, high_gain_video_strobe;
  logic       antibloom_on, hclk1_q, vclk_q, shut_q;
  int         transfers, last_width, n_errors, checks_done, cyc, last_v, last_s;
  int         n_pix, n_hra, n_lgu, n_ref, n_vid, n_lgr, n_hgr, n_vck;
  int         seed = 32'h54CBE7E4;

  ccd_timing_ctrl i_ccd_timing_ctrl (
    .clk, .resetn, .start_frame, .quarter_res, .gain_mode, .constant_hrate,
    .shutter_req, .shutter_in_frame, .top_transfer_phase, .bottom_transfer_phase,
    .vclk, .hclk1, .hclk2, .high_gain_reset_a, .high_gain_reset_b, .high_gain_reset_c,
    .low_gain_reset_upper, .low_gain_reset_lower, .shutter_pulse,
    .reference_sample_strobe, .video_sample_strobe, .low_gain_reference_strobe,
    .low_gain_video_strobe, .high_gain_reference_strobe, .high_gain_video_strobe, .busy
  );

  ccd_sensor_model i_ccd_sensor_model (
    .clk, .resetn, .top_transfer_phase, .bottom_transfer_phase,
    .antibloom_on, .transfers, .last_width
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input bit ok, input string msg);
    checks_done++;
    if (!ok)
    begin
      n_errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Bounded wait for a level on one design output
  task automatic wait_for(ref logic sig, input logic lvl, input int lim, input string msg);
    int n;
    n = 0;
    while (sig !== lvl && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    if (sig !== lvl)
    begin
      check(1'b0, msg);
      complete_run();
    end
  endtask

  // Expected pulse count for a given pixel count
  function automatic int want(input int pix, input bit on, input bit half);
    return on ? (half ? pix / 2 : pix) : 0;
  endfunction

  function automatic bit near(input int got, input int exp);
    return got >= exp - 1 && got <= exp + 1;
  endfunction

  task automatic apply_reset(input int n);
    resetn = 1'b0;
    repeat (n) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    check(busy === 1'b0 && top_transfer_phase === 1'b0 && hclk2 === 1'b1, "not idle");
  endtask

  task automatic begin_frame();
    int t0;
    t0 = transfers;
    repeat (2 + $unsigned($random(seed)) % 5) @(negedge clk);
    start_frame = 1'b1;
    @(negedge clk);
    start_frame = 1'b0;
    wait_for(top_transfer_phase, 1'b1, 3, "no transfer pulse");
    check(bottom_transfer_phase === 1'b1 && busy === 1'b1, "phases differ");
    check(antibloom_on === 1'b0, "blooming drain active in transfer");
    repeat (100) @(negedge clk);
    // A second start while busy must be ignored
    start_frame = 1'b1;
    @(negedge clk);
    start_frame = 1'b0;
    wait_for(top_transfer_phase, 1'b0, 300, "transfer never ends");
    repeat (2) @(negedge clk);
    check(transfers == t0 + 1 && last_width == XFER_CYC, "transfer width");
  endtask

  task automatic shutter(input logic in_frame);
    shutter_in_frame = in_frame;
    shutter_req = 1'b1;
    @(negedge clk);
    shutter_req = 1'b0;
    wait_for(shutter_pulse, 1'b1, 10000, "shutter never issued");
    wait_for(shutter_pulse, 1'b0, 400, "shutter never ends");
    repeat (2 * VHALF_CYC) @(negedge clk);
  endtask

  // Pulse counters and edge-spacing monitor
  always @(posedge clk)
  begin
    cyc++;
    if (resetn === 1'b1 && vclk !== vclk_q)
    begin
      check(cyc - last_s >= VHALF_CYC, "vertical edge near shutter");
      last_v = cyc;
    end
    if (resetn === 1'b1 && shutter_pulse !== shut_q)
    begin
      check(cyc - last_v >= VHALF_CYC, "shutter edge near vertical edge");
      if (shutter_pulse === 1'b0)
        check(cyc - last_s == ((shutter_in_frame === 1'b1) ? VHALF_CYC : SHUT_CYC),
              "shutter width");
      last_s = cyc;
    end
    if (busy === 1'b1 && hclk1 === hclk2)
      check(1'b0, "horizontal clocks not complementary");
    if (clr_cnt)
      {n_pix, n_hra, n_lgu, n_ref, n_vid, n_lgr, n_hgr, n_vck} = '0;
    n_pix += int'(hclk1 === 1'b1 && hclk1_q === 1'b0);
    n_hra += int'(high_gain_reset_a === 1'b1);
    n_lgu += int'(low_gain_reset_upper === 1'b1);
    n_ref += int'(reference_sample_strobe === 1'b1);
    n_vid += int'(video_sample_strobe === 1'b1);
    n_lgr += int'(low_gain_reference_strobe === 1'b1);
    n_hgr += int'(high_gain_reference_strobe === 1'b1);
    n_vck += int'(vclk === 1'b1 && vclk_q === 1'b0);
    hclk1_q = hclk1;
    vclk_q = vclk;
    shut_q = shutter_pulse;
  end

  initial
  begin
    {resetn, start_frame, quarter_res, constant_hrate, shutter_req} = '0;
    {shutter_in_frame, clr_cnt, hclk1_q, vclk_q, shut_q} = '0;
    gain_mode = GAIN_HIGH;
    {n_errors, checks_done, cyc} = '0;
    last_v = -1000;
    last_s = -1000;
    apply_reset(20);
    for (int m = 0; m < 6; m++)
    begin
      gain_mode = 2'(m % 3);
      quarter_res = 1'(m / 3);
      constant_hrate = 1'($random(seed));
      apply_reset(3);
      begin_frame();
      clr_cnt = 1'b1;
      @(negedge clk);
      clr_cnt = 1'b0;
      repeat (1500) @(negedge clk);
      check(n_pix > 0, "no pixel clocks");
      if (m % 3 == 0)
      begin
        check(near(n_hra, want(n_pix, 1'b1, quarter_res)), "high gain resets");
        check(n_lgu == 0, "low gain reset pulsed in high gain");
      end
      if (m % 3 == 1)
      begin
        check(n_hra == 0, "high gain reset pulsed in low gain");
        check(near(n_lgu, want(n_pix, 1'b1, quarter_res)), "low gain resets");
      end
      if (m % 3 != 2)
      begin
        check(near(n_ref, want(n_pix, 1'b1, quarter_res)), "reference strobes");
        check(near(n_vid, want(n_pix, 1'b1, quarter_res)), "video strobes");
      end
      else
        check(n_lgr > 0 && near(n_lgr, n_hgr), "extended strobe pairs");
      check(n_vck == ((m % 3 == 2) ? 2 : 1), "vertical shifts before readout");
    end
    gain_mode = GAIN_HIGH;
    quarter_res = 1'b0;
    apply_reset(3);
    begin_frame();
    shutter(1'b0);
    shutter(1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
